// >>> verilog/asai_pkg.sv
// Package of constants for the converter-start and add instruction executor
package asai_pkg;
    // ----------------------------------------
    // Widths and bit positions
    // ----------------------------------------
    localparam int unsigned NIB_W = 4;
    localparam int unsigned CTRL_MODE_BIT = 3;
    // ----------------------------------------
    // Operation select codes
    // ----------------------------------------
    localparam logic [2:0] OP_NONE = 3'h0;
    localparam logic [2:0] OP_CONVERT_START = 3'h1;
    localparam logic [2:0] OP_ADD_MEMORY = 3'h2;
    localparam logic [2:0] OP_ADD_MEMORY_CARRY = 3'h3;
    localparam logic [2:0] OP_ADD_IMMEDIATE = 3'h4;
    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam logic [3:0] ACC_RESET = 4'h0;
    localparam logic CARRY_RESET = 1'b0;
    localparam logic DONE_RESET = 1'b0;
endpackage

// >>> verilog/asai_adder.sv
// Four-bit adder with carry in and carry out
`timescale 1ns/1ns
module asai_adder #(
    parameter int unsigned WIDTH = 4
) (
    input wire logic [WIDTH-1:0] a,
    input wire logic [WIDTH-1:0] b,
    input wire logic cin,
    output logic [WIDTH-1:0] sum,
    output logic cout
);
    logic [WIDTH:0] full;
    always_comb begin
        full = {1'b0, a} + {1'b0, b} + {{WIDTH{1'b0}}, cin};
        sum = full[WIDTH-1:0];
        cout = full[WIDTH];
    end
endmodule // asai_adder

// >>> verilog/asai_exec.sv
// Executor for converter start, add-memory, add-memory-with-carry and immediate add
//
// Summary of operation
// [RL1] Converter start clears the conversion-done flag.
// [RL2] Mode bit 0: converter start begins an A/D conversion.
// [RL3] Mode bit 1: converter start begins comparator operation instead.
// [RL4] Add-memory puts accumulator plus addressed memory nibble into accumulator.
// [RL5] Add-memory leaves the carry flag untouched.
// [RL6] Add-memory-with-carry adds carry too and loads carry-out into carry flag.
// [RL7] Immediate add takes 0 to 15 and skips next instruction on overflow.
// [RL8] Immediate add never alters the carry flag.
// [RL9] Each instruction is one word and completes in one machine cycle.
// [RL10] Mode bit is bit 3 of the converter control register.
// [RL11] Nibbles are 4 bits; sums modulo 16; overflow is carry out of bit 3.
`timescale 1ns/1ns
module asai_exec (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic op_valid,
    input wire logic [2:0] op_sel,
    input wire logic [3:0] immediate,
    input wire logic [3:0] mem_nibble,
    input wire logic [3:0] converter_control_reg,
    input wire logic conversion_complete,
    output logic [3:0] accumulator,
    output logic carry_flag,
    output logic conversion_done_flag,
    output logic skip_next,
    output logic conversion_start,
    output logic comparator_start,
    output logic op_done
);

    // ----------------------------------------
    // Operation decode
    // ----------------------------------------
    logic do_convert;
    logic do_add_memory;
    logic do_add_carry;
    logic do_add_immediate;
    logic do_any;

    // Refused codes raise no strobe, so they change nothing
    always_comb begin
        do_convert = 1'b0;
        do_add_memory = 1'b0;
        do_add_carry = 1'b0;
        do_add_immediate = 1'b0;
        if (op_valid) begin
            case (op_sel)
                asai_pkg::OP_CONVERT_START: begin
                    do_convert = 1'b1;
                end
                asai_pkg::OP_ADD_MEMORY: begin
                    do_add_memory = 1'b1;
                end
                asai_pkg::OP_ADD_MEMORY_CARRY: begin
                    do_add_carry = 1'b1;
                end
                asai_pkg::OP_ADD_IMMEDIATE: begin
                    do_add_immediate = 1'b1;
                end
                default: begin
                    do_convert = 1'b0;
                end
            endcase
        end
        do_any = do_convert | do_add_memory | do_add_carry | do_add_immediate;
    end

    // ----------------------------------------
    // Arithmetic
    // ----------------------------------------
    logic add_cin;
    logic [3:0] add_b;
    logic [3:0] add_sum;
    logic add_cout;

    always_comb begin
        // Immediate add takes its operand from the instruction, the others from memory
        add_b = do_add_immediate ? immediate : mem_nibble;
        add_cin = do_add_carry ? carry_flag : 1'b0; // [RL6]
    end

    // One adder serves all three adds; only the with-carry form keeps its carry-out
    asai_adder #(
        .WIDTH(asai_pkg::NIB_W)
    ) asai_adder_inst (
        .a(accumulator),
        .b(add_b),
        .cin(add_cin),
        .sum(add_sum),
        .cout(add_cout)
    ); // [RL11]

    // ----------------------------------------
    // Accumulator
    // ----------------------------------------
    logic [3:0] next_accumulator;

    always_comb begin
        next_accumulator = accumulator;
        // The fifth bit of the sum is dropped, so results wrap modulo 16
        if (do_add_memory || do_add_carry || do_add_immediate) begin
            next_accumulator = add_sum; // [RL4] [RL6] [RL7] [RL11]
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            accumulator <= asai_pkg::ACC_RESET;
        end else begin
            accumulator <= next_accumulator;
        end
    end

    // ----------------------------------------
    // Carry flag
    // ----------------------------------------
    logic next_carry_flag;

    always_comb begin
        // Plain and immediate adds hold the flag even when they overflow
        next_carry_flag = carry_flag; // [RL5] [RL8]
        if (do_add_carry) begin
            next_carry_flag = add_cout; // [RL6]
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            carry_flag <= asai_pkg::CARRY_RESET;
        end else begin
            carry_flag <= next_carry_flag;
        end
    end

    // ----------------------------------------
    // Conversion-done flag
    // ----------------------------------------
    logic next_conversion_done_flag;

    always_comb begin
        // Completion sets the flag; a start in the same cycle still clears it,
        // since the new conversion supersedes the one that just ended
        next_conversion_done_flag = conversion_done_flag | conversion_complete;
        if (do_convert) begin
            next_conversion_done_flag = 1'b0; // [RL1]
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            conversion_done_flag <= asai_pkg::DONE_RESET;
        end else begin
            conversion_done_flag <= next_conversion_done_flag;
        end
    end

    // ----------------------------------------
    // Converter start
    // ----------------------------------------
    logic mode_bit;
    logic next_conversion_start;
    logic next_comparator_start;

    always_comb begin
        mode_bit = converter_control_reg[asai_pkg::CTRL_MODE_BIT]; // [RL10]
        next_conversion_start = 1'b0;
        next_comparator_start = 1'b0;
        // Exactly one of the two starts fires; the mode bit picks which
        if (do_convert) begin
            next_conversion_start = ~mode_bit; // [RL2]
            next_comparator_start = mode_bit; // [RL3]
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            conversion_start <= 1'b0;
            comparator_start <= 1'b0;
        end else begin
            conversion_start <= next_conversion_start;
            comparator_start <= next_comparator_start;
        end
    end

    // ----------------------------------------
    // Skip request
    // ----------------------------------------
    logic next_skip_next;

    always_comb begin
        // Overflow of the immediate add makes the sequencer pass over the next word
        next_skip_next = do_add_immediate & add_cout; // [RL7]
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            skip_next <= 1'b0;
        end else begin
            skip_next <= next_skip_next;
        end
    end

    // ----------------------------------------
    // Completion
    // ----------------------------------------
    logic next_op_done;

    always_comb begin
        // Every accepted instruction finishes in the cycle that takes it
        next_op_done = do_any; // [RL9]
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            op_done <= 1'b0;
        end else begin
            op_done <= next_op_done;
        end
    end
endmodule // asai_exec

// >>> tb/asai_exec_asserts.sv
// Port checker for the instruction executor
`timescale 1ns/1ns
module asai_exec_asserts (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic op_valid,
    input wire logic [2:0] op_sel,
    input wire logic [3:0] immediate,
    input wire logic [3:0] mem_nibble,
    input wire logic [3:0] converter_control_reg,
    input wire logic conversion_complete,
    input wire logic [3:0] accumulator,
    input wire logic carry_flag,
    input wire logic conversion_done_flag,
    input wire logic skip_next,
    input wire logic conversion_start,
    input wire logic comparator_start,
    input wire logic op_done
);
default clocking @(posedge clk); endclocking
default disable iff (!arst_n);
// Zero when idle, so one compare covers valid and select
wire logic [2:0] s = op_valid ? op_sel : 3'h0;
wire logic m = converter_control_reg[3];
a_start_clear: assert property (s == 3'h1 |=> !conversion_done_flag)
    else $error("done flag kept");
a_adc_begin: assert property (s == 3'h1 && !m |=> conversion_start && !comparator_start)
    else $error("no conversion start");
a_cmp_begin: assert property (s == 3'h1 && m |=> comparator_start && !conversion_start)
    else $error("no comparator start");
a_add_mem: assert property (s == 3'h2 |=> accumulator == $past(accumulator) + $past(mem_nibble))
    else $error("bad sum");
a_carry_kept: assert property (s == 3'h2 || s == 3'h4 |=> $stable(carry_flag))
    else $error("carry changed");
a_add_carry: assert property (s == 3'h3 |=> {carry_flag, accumulator} ==
    {1'b0, $past(accumulator)} + $past(mem_nibble) + $past(carry_flag))
    else $error("bad carry sum");
a_imm_skip: assert property (s == 3'h4 |=> skip_next == ({1'b0, $past(accumulator)} + $past(immediate) > 5'h0f))
    else $error("bad skip");
a_one_cycle: assert property (s inside {[3'h1:3'h4]} |=> op_done)
    else $error("op not done");
a_idle_quiet: assert property (!(s inside {[3'h1:3'h4]}) |=>
    !op_done && !skip_next && !conversion_start && !comparator_start)
    else $error("stray pulse");
a_idle_hold: assert property (!(s inside {[3'h2:3'h4]}) |=> $stable(accumulator) && $stable(carry_flag))
    else $error("state changed without add");
endmodule // asai_exec_asserts
bind asai_exec asai_exec_asserts asai_exec_asserts_inst (.*);

// >>> tb/asai_exec_bench.sv
// Self-checking bench for the instruction executor
`timescale 1ns/1ns
module asai_exec_bench;
logic clk = 1'b0, arst_n = 1'b0, op_valid = 1'b0, conversion_complete = 1'b0, cy = 1'b0, df = 1'b0;
logic carry_flag, conversion_done_flag, skip_next, conversion_start, comparator_start, op_done;
logic [2:0] op_sel = 3'h0;
logic [3:0] immediate = 4'h0, mem_nibble = 4'h0, converter_control_reg = 4'h0, accumulator, acc = 4'h0;
int failures = 0, checks_done = 0;
always #4 clk = ~clk;
asai_exec asai_exec_inst (.*);
task check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
        failures++;
        $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
endtask
function automatic logic [4:0] sum5(input logic [3:0] a, input logic [3:0] b, input logic c);
    return {1'b0, a} + b + c;
endfunction
task conclude;
    if (failures == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
endtask
// One op per cycle; held valid gives back-to-back issue
task step(input logic v, input logic [2:0] op, input logic [3:0] im, mn, cr, input logic cc);
    logic [4:0] r;
    r = sum5(acc, op == 3'h4 ? im : mn, op == 3'h3 && cy);
    {op_valid, op_sel, immediate, mem_nibble, converter_control_reg, conversion_complete} = {v, op, im, mn, cr, cc};
    if (cc) df = 1'b1;
    if (v && op == 3'h1) df = 1'b0;
    if (v && op == 3'h3) cy = r[4];
    if (v && op inside {[3'h2:3'h4]}) acc = r[3:0];
    @(negedge clk);
    check(8'(accumulator), 8'(acc));
    check(8'(carry_flag), 8'(cy));
    check(8'(conversion_done_flag), 8'(df));
    check(8'(skip_next), 8'(v && op == 3'h4 && r[4]));
    check(8'(op_done), 8'(v && op inside {[3'h1:3'h4]}));
    check(8'(conversion_start), 8'(v && op == 3'h1 && !cr[3]));
    check(8'(comparator_start), 8'(v && op == 3'h1 && cr[3]));
endtask
// Mid-run reset: all outputs read zero while held, and the model restarts
task pulse_reset;
    arst_n = 1'b0;
    op_valid = 1'b0;
    @(negedge clk);
    check({accumulator, carry_flag, conversion_done_flag, skip_next, op_done}, 8'h00);
    check({6'h00, conversion_start, comparator_start}, 8'h00);
    repeat (2) @(negedge clk);
    arst_n = 1'b1;
    {acc, cy, df} = 6'h00;
endtask
initial begin
    void'($urandom(32'h74807a3b));
    repeat (8) @(posedge clk);
    @(negedge clk) arst_n = 1;
    step(1'b1, 3'h2, 4'h0, 4'hc, 4'h0, 1'b0);
    step(1'b1, 3'h4, 4'h5, 4'h0, 4'h0, 1'b0);
    step(1'b1, 3'h4, 4'h3, 4'h0, 4'h0, 1'b0);
    step(1'b1, 3'h3, 4'h0, 4'hf, 4'h0, 1'b0);
    step(1'b1, 3'h2, 4'h0, 4'hf, 4'h0, 1'b0);
    step(1'b1, 3'h4, 4'hf, 4'h0, 4'h0, 1'b0);
    step(1'b1, 3'h3, 4'h0, 4'hf, 4'h0, 1'b0);
    step(1'b0, 3'h1, 4'h0, 4'h0, 4'h8, 1'b1);
    step(1'b1, 3'h1, 4'h0, 4'h0, 4'h8, 1'b0);
    step(1'b1, 3'h1, 4'h0, 4'h0, 4'h7, 1'b1);
    for (int k = 5; k < 9; k++) step(1'b1, 3'(k), 4'hf, 4'hf, 4'hf, 1'b0);
    pulse_reset;
    step(1'b1, 3'h4, 4'hf, 4'h0, 4'h0, 1'b0);
    repeat (150) step(1'($urandom), 3'($urandom), 4'($urandom), 4'($urandom), 4'($urandom), 1'($urandom));
    pulse_reset;
    repeat (150) step(1'($urandom), 3'($urandom), 4'($urandom), 4'($urandom), 4'($urandom), 1'($urandom));
    conclude;
end
endmodule // asai_exec_bench
